// >>> logic/lcsr_pkg.sv
// Constants shared by the command/status register set and its setup sequencer
`default_nettype none
package lcsr_pkg;
  // Host port byte offsets in short I/O space
  localparam logic [11:0] OFS_BOARD_CTRL   = 12'h000;
  localparam logic [11:0] OFS_DATA_WINDOW  = 12'h004;
  localparam logic [11:0] OFS_SELECT_PORT  = 12'h006;
  // Register select codes
  localparam logic [1:0]  SEL_MAIN         = 2'h0;
  localparam logic [1:0]  SEL_PTR_LOW      = 2'h1;
  localparam logic [1:0]  SEL_PTR_HIGH     = 2'h2;
  localparam logic [1:0]  SEL_BUS_CFG      = 2'h3;
  // command_status_main bit positions
  localparam int          B_ERR_SUMMARY    = 15;
  localparam int          B_BABBLE         = 14;
  localparam int          B_MISSED         = 12;
  localparam int          B_MEM_FAULT      = 11;
  localparam int          B_RX_DONE        = 10;
  localparam int          B_TX_DONE        = 9;
  localparam int          B_SETUP_DONE     = 8;
  localparam int          B_INT_SUMMARY    = 7;
  localparam int          B_INT_ENABLE     = 6;
  localparam int          B_RX_ACTIVE      = 5;
  localparam int          B_TX_ACTIVE      = 4;
  localparam int          B_TX_POLL        = 3;
  localparam int          B_HALT           = 2;
  localparam int          B_START          = 1;
  localparam int          B_SETUP_REQ      = 0;
  // Sticky flag vector order: babble, missed, mem fault, rx done, tx done, setup done
  localparam int          NUM_FLAGS        = 6;
  localparam int          F_BABBLE         = 5;
  localparam int          F_MISSED         = 4;
  localparam int          F_MEM_FAULT      = 3;
  localparam int          F_RX_DONE        = 2;
  localparam int          F_TX_DONE        = 1;
  localparam int          F_SETUP_DONE     = 0;
  // board_control_register fields
  localparam int          BC_LEVEL_MSB     = 2;
  localparam int          BC_GATE_N        = 4;
  localparam int          BC_HARD_RESET    = 6;
  localparam logic [2:0]  IRQ_LEVEL_NONE   = 3'h7;
  localparam logic [2:0]  BC_LEVEL_RESET   = 3'h7;
  // bus_master_config fields
  localparam int          CFG_WIDTH        = 3;
  // Setup block layout, word indices
  localparam int          SETUP_WORDS      = 12;
  localparam logic [3:0]  W_MODE           = 4'h0;
  localparam logic [3:0]  W_LAST           = 4'hb;
  localparam int          W_NODE           = 1;
  localparam int          W_FILTER         = 4;
  localparam int          W_RX_RING        = 8;
  localparam int          W_TX_RING        = 10;
  // Mode word bits
  localparam int          M_ACCEPT_ALL     = 15;
  localparam int          M_INTERNAL_ECHO  = 6;
  localparam int          M_LOOPBACK       = 2;
  localparam int          M_TX_DISABLE     = 1;
  localparam int          M_RX_DISABLE     = 0;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE  = 3'b100
  } lcsr_state_e;
endpackage : lcsr_pkg
`default_nettype wire

// >>> logic/lcsr_top.sv
// Command/status registers, interrupt gating and setup-block sequencer
`default_nettype none
module lcsr_top (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        SYSRESET_N,
  input  wire logic        HOST_CS,
  input  wire logic        HOST_WE,
  input  wire logic [11:0] HOST_ADDR,
  input  wire logic [15:0] HOST_WDATA,
  output logic      [15:0] HOST_RDATA,
  output logic             MEM_REQ,
  output logic      [23:0] MEM_ADDR,
  input  wire logic        MEM_ACK,
  input  wire logic [15:0] MEM_RDATA,
  input  wire logic        BABBLE_EV,
  input  wire logic        MISSED_EV,
  input  wire logic        MEM_FAULT_EV,
  input  wire logic        RX_DONE_EV,
  input  wire logic        TX_DONE_EV,
  input  wire logic        FIFO_UNDERFLOW_EV,
  input  wire logic        BUFFER_ERROR_EV,
  input  wire logic        TX_POLL_TAKEN,
  output logic             TX_POLL_NOW,
  output logic             VME_IRQ,
  output logic      [2:0]  VME_IRQ_LEVEL,
  output logic             HALTED,
  output logic             RX_ACTIVE,
  output logic             TX_ACTIVE,
  output logic      [47:0] NODE_ADDRESS,
  output logic      [63:0] MULTICAST_FILTER,
  output logic      [23:0] RX_RING_BASE,
  output logic      [2:0]  RX_RING_SIZE,
  output logic      [23:0] TX_RING_BASE,
  output logic      [2:0]  TX_RING_SIZE,
  output logic             ACCEPT_ALL,
  output logic             LOOPBACK,
  output logic             INTERNAL_ECHO
);

  ////////////////////////////////////////////////////////////////////////////
  // System reset pin: three stages, level moves only when stages 2 and 3 agree
  logic       sys_q1;
  logic       sys_q2;
  logic       sys_q3;
  logic       sys_reset_lvl;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sys_q1 <= 1'b1;
      sys_q2 <= 1'b1;
      sys_q3 <= 1'b1;
      sys_reset_lvl <= 1'b0;
    end else begin
      sys_q1 <= SYSRESET_N;
      sys_q2 <= sys_q1;
      sys_q3 <= sys_q2;
      if (sys_q2 == sys_q3) begin
        sys_reset_lvl <= ~sys_q3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host decode
  localparam int NUM_FLAGS = lcsr_pkg::NUM_FLAGS;
  logic [1:0]  reg_select;
  logic [2:0]  irq_level;
  logic        irq_gate_n;
  logic        halt;
  logic        start;
  logic        setup_req;
  logic        int_enable;
  logic        tx_poll_now;
  logic        rx_active;
  logic        tx_active;
  logic [NUM_FLAGS-1:0] flags;
  logic [15:0] ptr_low;
  logic [7:0]  ptr_high;
  logic [lcsr_pkg::CFG_WIDTH-1:0] bus_cfg;
  logic [15:0] setup_mem [lcsr_pkg::SETUP_WORDS];
  logic [3:0]  word_idx;
  lcsr_pkg::lcsr_state_e state;

  wire host_wr    = HOST_CS & HOST_WE;
  wire wr_bctrl   = host_wr & (HOST_ADDR == lcsr_pkg::OFS_BOARD_CTRL);
  wire wr_select  = host_wr & (HOST_ADDR == lcsr_pkg::OFS_SELECT_PORT);
  wire wr_window  = host_wr & (HOST_ADDR == lcsr_pkg::OFS_DATA_WINDOW);
  wire wr_main    = wr_window & (reg_select == lcsr_pkg::SEL_MAIN);
  // pointer and config writes drop unless halted
  wire wr_ptr_low = wr_window & halt & (reg_select == lcsr_pkg::SEL_PTR_LOW);
  wire wr_ptr_hi  = wr_window & halt & (reg_select == lcsr_pkg::SEL_PTR_HIGH);
  wire wr_cfg     = wr_window & halt & (reg_select == lcsr_pkg::SEL_BUS_CFG);

  wire hard_reset_evt = wr_bctrl & HOST_WDATA[lcsr_pkg::BC_HARD_RESET];
  wire board_reset    = hard_reset_evt | sys_reset_lvl;
  // halt in the same write masks start and setup
  wire halt_wr   = wr_main & HOST_WDATA[lcsr_pkg::B_HALT];
  wire start_wr  = wr_main & HOST_WDATA[lcsr_pkg::B_START] & ~HOST_WDATA[lcsr_pkg::B_HALT];
  wire setup_wr  = wr_main & HOST_WDATA[lcsr_pkg::B_SETUP_REQ] & ~HOST_WDATA[lcsr_pkg::B_HALT];
  // halt clears commands, flags, sequencer and pointers; setup words and board control are kept
  wire halt_evt  = halt_wr | board_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Setup sequencer
  wire [15:0] mode_word   = setup_mem[lcsr_pkg::W_MODE];
  wire        fetch_beat  = (state == lcsr_pkg::ST_FETCH) & MEM_ACK;
  // done only after the last of the twelve words lands
  wire        setup_cmpl  = fetch_beat & (word_idx == lcsr_pkg::W_LAST);
  wire [23:0] setup_base  = {ptr_high, ptr_low[15:1], 1'b0};

  lcsr_pkg::lcsr_state_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      lcsr_pkg::ST_IDLE: begin
        if (setup_wr) begin
          next_state = lcsr_pkg::ST_FETCH;
        end
      end
      lcsr_pkg::ST_FETCH: begin
        if (setup_cmpl) begin
          next_state = lcsr_pkg::ST_DONE;
        end
      end
      lcsr_pkg::ST_DONE: begin
        next_state = lcsr_pkg::ST_IDLE;
      end
      default: next_state = lcsr_pkg::ST_IDLE;
    endcase
    if (halt_evt) begin
      next_state = lcsr_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state    <= lcsr_pkg::ST_IDLE;
      word_idx <= 4'h0;
    end else begin
      state <= next_state;
      if (next_state != lcsr_pkg::ST_FETCH) begin
        word_idx <= 4'h0;
      end else if (fetch_beat) begin
        word_idx <= word_idx + 4'h1;
      end
    end
  end

  // word address walks the block two bytes per word
  assign MEM_REQ  = (state == lcsr_pkg::ST_FETCH);
  assign MEM_ADDR = setup_base + {19'h0, word_idx, 1'b0};

  // Setup words survive halt so stale parameters stay visible to the engine
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < lcsr_pkg::SETUP_WORDS; i++) begin
        setup_mem[i] <= 16'h0;
      end
    end else if (fetch_beat) begin
      setup_mem[word_idx] <= MEM_RDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command bits
  wire start_go = (start_wr & ~setup_wr & (state == lcsr_pkg::ST_IDLE))
                | (setup_cmpl & (start | start_wr));
  wire rx_off   = halt_evt | MEM_FAULT_EV
                | (setup_cmpl & mode_word[lcsr_pkg::M_RX_DISABLE]);
  wire tx_off   = halt_evt | MEM_FAULT_EV | FIFO_UNDERFLOW_EV | BUFFER_ERROR_EV
                | (setup_cmpl & mode_word[lcsr_pkg::M_TX_DISABLE]);

  // halt set by one, cleared by start or setup
  wire next_halt = halt_evt ? 1'b1 : ((start_wr | setup_wr) ? 1'b0 : halt);
  // start and setup are write-one-to-set, cleared by halt
  wire next_start     = halt_evt ? 1'b0 : (start_wr | start);
  wire next_setup_req = halt_evt ? 1'b0 : (setup_wr | setup_req);
  wire next_rx_active = rx_off ? 1'b0
                      : ((start_go & ~mode_word[lcsr_pkg::M_RX_DISABLE]) | rx_active);
  wire next_tx_active = tx_off ? 1'b0
                      : ((start_go & ~mode_word[lcsr_pkg::M_TX_DISABLE]) | tx_active);
  // demand wins over the consumer's acknowledge
  wire poll_wr        = wr_main & HOST_WDATA[lcsr_pkg::B_TX_POLL] & ~halt;
  wire next_tx_poll   = halt_evt ? 1'b0 : (poll_wr | (tx_poll_now & ~TX_POLL_TAKEN));
  // interrupt enable read/write, cleared by halt
  wire next_int_en    = halt_evt ? 1'b0
                      : (wr_main ? HOST_WDATA[lcsr_pkg::B_INT_ENABLE] : int_enable);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      halt        <= 1'b1;
      start       <= 1'b0;
      setup_req   <= 1'b0;
      rx_active   <= 1'b0;
      tx_active   <= 1'b0;
      tx_poll_now <= 1'b0;
      int_enable  <= 1'b0;
    end else begin
      halt        <= next_halt;
      start       <= next_start;
      setup_req   <= next_setup_req;
      rx_active   <= next_rx_active;
      tx_active   <= next_tx_active;
      tx_poll_now <= next_tx_poll;
      int_enable  <= next_int_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags, set beats host clear in the same cycle
  wire [NUM_FLAGS-1:0] flag_set = {BABBLE_EV, MISSED_EV, MEM_FAULT_EV,
                                   RX_DONE_EV, TX_DONE_EV, setup_cmpl};
  wire [NUM_FLAGS-1:0] flag_clr = {NUM_FLAGS{wr_main}} & {
                                   HOST_WDATA[lcsr_pkg::B_BABBLE],
                                   HOST_WDATA[lcsr_pkg::B_MISSED],
                                   HOST_WDATA[lcsr_pkg::B_MEM_FAULT],
                                   HOST_WDATA[lcsr_pkg::B_RX_DONE],
                                   HOST_WDATA[lcsr_pkg::B_TX_DONE],
                                   HOST_WDATA[lcsr_pkg::B_SETUP_DONE]};
  // write-one-to-clear, halt clears; setup done via flag_set
  wire [NUM_FLAGS-1:0] next_flags = halt_evt ? {NUM_FLAGS{1'b0}}
                                  : (flag_set | (flags & ~flag_clr));
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      flags <= {NUM_FLAGS{1'b0}};
    end else begin
      flags <= next_flags;
    end
  end

  // summary is a pure OR, no storage
  wire int_summary = |flags;
  wire err_summary = flags[lcsr_pkg::F_BABBLE] | flags[lcsr_pkg::F_MISSED]
                   | flags[lcsr_pkg::F_MEM_FAULT];

  ////////////////////////////////////////////////////////////////////////////
  // Board control and interrupt gating
  // all three conditions must hold
  wire irq_cond  = int_summary & int_enable & (irq_level != lcsr_pkg::IRQ_LEVEL_NONE);
  wire irq_raise = irq_cond & ~irq_gate_n & ~VME_IRQ;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reg_select <= lcsr_pkg::SEL_MAIN;
      irq_level  <= lcsr_pkg::BC_LEVEL_RESET;
      irq_gate_n <= 1'b1;
      VME_IRQ    <= 1'b0;
    end else begin
      if (board_reset) begin
        reg_select <= lcsr_pkg::SEL_MAIN;
      end else if (wr_select) begin
        reg_select <= HOST_WDATA[1:0];
      end
      if (wr_bctrl) begin
        irq_level <= HOST_WDATA[lcsr_pkg::BC_LEVEL_MSB:0];
      end
      // gate closes on raise, overriding a host reopen that cycle
      if (irq_raise) begin
        irq_gate_n <= 1'b1;
      // host reopens the gate by writing zero
      end else if (wr_bctrl) begin
        irq_gate_n <= HOST_WDATA[lcsr_pkg::BC_GATE_N];
      end
      // Request holds until its cause goes away
      VME_IRQ <= irq_raise | (VME_IRQ & irq_cond);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and bus configuration registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptr_low  <= 16'h0;
      ptr_high <= 8'h0;
      bus_cfg  <= '0;
    end else begin
      // contents lost whenever halt is set
      if (halt_evt) begin
        ptr_low  <= 16'h0;
        ptr_high <= 8'h0;
        bus_cfg  <= '0;
      end else begin
        // low bit 0 and high bits 15..8 are reserved as zero
        if (wr_ptr_low) begin
          ptr_low <= {HOST_WDATA[15:1], 1'b0};
        end
        if (wr_ptr_hi) begin
          ptr_high <= HOST_WDATA[7:0];
        end
        // only the three defined bits are kept
        if (wr_cfg) begin
          bus_cfg <= HOST_WDATA[lcsr_pkg::CFG_WIDTH-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  wire [15:0] main_word = {err_summary, flags[lcsr_pkg::F_BABBLE], 1'b0,
                           flags[lcsr_pkg::F_MISSED], flags[lcsr_pkg::F_MEM_FAULT],
                           flags[lcsr_pkg::F_RX_DONE], flags[lcsr_pkg::F_TX_DONE],
                           flags[lcsr_pkg::F_SETUP_DONE], int_summary, int_enable,
                           rx_active, tx_active, tx_poll_now, halt, start, setup_req};
  // select code picks the register behind the window
  wire [15:0] window_word = (reg_select == lcsr_pkg::SEL_MAIN)     ? main_word
                          : (reg_select == lcsr_pkg::SEL_PTR_LOW)  ? ptr_low
                          : (reg_select == lcsr_pkg::SEL_PTR_HIGH) ? {8'h0, ptr_high}
                          : {13'h0, bus_cfg};
  wire        window_ok   = (reg_select == lcsr_pkg::SEL_MAIN) | halt;
  wire [15:0] bctrl_word  = {11'h0, irq_gate_n, 1'b0, irq_level};
  wire [15:0] rd_mux = (HOST_ADDR == lcsr_pkg::OFS_DATA_WINDOW) ? (window_ok ? window_word : 16'h0)
                     : (HOST_ADDR == lcsr_pkg::OFS_SELECT_PORT) ? {14'h0, reg_select}
                     : (HOST_ADDR == lcsr_pkg::OFS_BOARD_CTRL)  ? bctrl_word
                     : 16'h0;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HOST_RDATA <= 16'h0;
    end else if (HOST_CS & ~HOST_WE) begin
      HOST_RDATA <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameters handed to the frame engine
  assign TX_POLL_NOW      = tx_poll_now;
  assign VME_IRQ_LEVEL    = irq_level;
  assign HALTED           = halt;
  assign RX_ACTIVE        = rx_active;
  assign TX_ACTIVE        = tx_active;
  assign NODE_ADDRESS     = {setup_mem[lcsr_pkg::W_NODE+2], setup_mem[lcsr_pkg::W_NODE+1],
                             setup_mem[lcsr_pkg::W_NODE]};
  assign MULTICAST_FILTER = {setup_mem[lcsr_pkg::W_FILTER+3], setup_mem[lcsr_pkg::W_FILTER+2],
                             setup_mem[lcsr_pkg::W_FILTER+1], setup_mem[lcsr_pkg::W_FILTER]};
  assign RX_RING_BASE = {setup_mem[lcsr_pkg::W_RX_RING+1][7:0], setup_mem[lcsr_pkg::W_RX_RING]};
  assign RX_RING_SIZE     = setup_mem[lcsr_pkg::W_RX_RING+1][15:13];
  assign TX_RING_BASE = {setup_mem[lcsr_pkg::W_TX_RING+1][7:0], setup_mem[lcsr_pkg::W_TX_RING]};
  assign TX_RING_SIZE     = setup_mem[lcsr_pkg::W_TX_RING+1][15:13];
  assign ACCEPT_ALL       = mode_word[lcsr_pkg::M_ACCEPT_ALL];
  // echo choice only meaningful with loopback on
  assign LOOPBACK         = mode_word[lcsr_pkg::M_LOOPBACK];
  assign INTERNAL_ECHO    = mode_word[lcsr_pkg::M_LOOPBACK] & mode_word[lcsr_pkg::M_INTERNAL_ECHO];

endmodule // lcsr_top
`default_nettype wire

// >>> bench/lcsr_chk.sv
// Port-level checks for the command/status register block
`default_nettype none
module lcsr_chk (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        HOST_CS,
  input wire logic        HOST_WE,
  input wire logic [11:0] HOST_ADDR,
  input wire logic [15:0] HOST_WDATA,
  input wire logic [15:0] HOST_RDATA,
  input wire logic        MEM_REQ,
  input wire logic        TX_POLL_NOW,
  input wire logic        VME_IRQ,
  input wire logic [2:0]  VME_IRQ_LEVEL,
  input wire logic        HALTED,
  input wire logic        RX_ACTIVE,
  input wire logic        TX_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic [1:0] sel;
  logic       gate_open;
  wire logic  wr_sel  = HOST_CS && HOST_WE && HOST_ADDR == lcsr_pkg::OFS_SELECT_PORT;
  wire logic  wr_bc   = HOST_CS && HOST_WE && HOST_ADDR == lcsr_pkg::OFS_BOARD_CTRL;
  wire logic  win     = HOST_CS && HOST_ADDR == lcsr_pkg::OFS_DATA_WINDOW;
  wire logic  wr_main = win && HOST_WE && sel == lcsr_pkg::SEL_MAIN;
  wire logic  rd_ptr  = win && !HOST_WE && sel != lcsr_pkg::SEL_MAIN;
  ////////////////////////////////////////////////////////////////////////////
  // Mirror of select port and gate; gate closes one edge late, harmless here
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel       <= 2'h0;
      gate_open <= 1'b0;
    end else begin
      if (wr_sel) sel <= HOST_WDATA[1:0];
      if (wr_bc) gate_open <= !HOST_WDATA[4];
      else if (VME_IRQ) gate_open <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_quiet; HALTED |-> !MEM_REQ && !RX_ACTIVE && !TX_ACTIVE && !TX_POLL_NOW; endproperty
  a_quiet: assert property (p_quiet)
    else $error("activity while halted");
  property p_halt_wins; wr_main && HOST_WDATA[2] |=> HALTED && !MEM_REQ; endproperty
  a_halt_wins: assert property (p_halt_wins)
    else $error("halt write did not win");
  property p_start; wr_main && HOST_WDATA[1] && !HOST_WDATA[2] |=> !HALTED; endproperty
  a_start: assert property (p_start)
    else $error("start left halt set");
  property p_setup; HALTED && wr_main && HOST_WDATA[0] && !HOST_WDATA[2] |=> MEM_REQ; endproperty
  a_setup: assert property (p_setup)
    else $error("setup request did not start fetch");
  property p_level; $rose(VME_IRQ) |-> VME_IRQ_LEVEL != lcsr_pkg::IRQ_LEVEL_NONE; endproperty
  a_level: assert property (p_level)
    else $error("interrupt raised at level none");
  property p_gate; $rose(VME_IRQ) |-> $past(gate_open); endproperty
  a_gate: assert property (p_gate)
    else $error("interrupt raised with gate closed");
  property p_poll;
    wr_main && HOST_WDATA[3] && !HOST_WDATA[2] && !HALTED |=> TX_POLL_NOW;
  endproperty
  a_poll: assert property (p_poll)
    else $error("poll demand not raised");
  property p_rd_undef; !HALTED && rd_ptr |=> HOST_RDATA == 16'h0000; endproperty
  a_rd_undef: assert property (p_rd_undef)
    else $error("pointer read returned data while running");
endmodule // lcsr_chk
bind lcsr_top lcsr_chk u_chk (.CLK, .RESET_N, .HOST_CS, .HOST_WE, .HOST_ADDR, .HOST_WDATA,
  .HOST_RDATA, .MEM_REQ, .TX_POLL_NOW, .VME_IRQ, .VME_IRQ_LEVEL, .HALTED, .RX_ACTIVE,
  .TX_ACTIVE);
`default_nettype wire

// >>> bench/lcsr_mem_model.sv
// Board memory holding the setup block, answering fetch requests
`default_nettype none
module lcsr_mem_model #(
  parameter logic [23:0] BASE = 24'h561200
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]        wait_cnt;
  wire logic [23:0]  ofs = mem_addr - BASE;
  wire logic [15:0]  word = (ofs > 24'h16 || ofs[0]) ? 16'hdead :
                            (ofs == 24'h0) ? 16'h8046 : 16'ha000 + {12'h0, ofs[4:1]};
  // Odd words answer slowly; bus shows a toggling pattern when not acking
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h5a5a;
      wait_cnt  <= 2'h0;
    end else if (mem_req && !mem_ack && wait_cnt == {ofs[1], 1'b0}) begin
      mem_ack   <= 1'b1;
      mem_rdata <= word;
      wait_cnt  <= 2'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule // lcsr_mem_model
`default_nettype wire

// >>> bench/test_lan_csr_init_control.sv
// Self-checking bench for the command/status register block
`default_nettype none
module test_lan_csr_init_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, reset_n = 1'b0, sysreset_n = 1'b1, cs = 1'b0, we = 1'b0;
  logic        taken = 1'b0, mem_req, mem_ack, poll, irq, halted, rxa, txa, acc, loop, echo;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000, rdata, mem_rdata, v;
  logic [6:0]  ev = 7'h00;
  logic [23:0] mem_addr, rxb, txb;
  logic [2:0]  rxs, txs, lvl;
  logic [47:0] node;
  logic [63:0] filt;
  int          miscompares = 0;
  int          cmp_count = 0;
  always #50 clk = ~clk;
  lcsr_top u_dut (.CLK(clk), .RESET_N(reset_n), .SYSRESET_N(sysreset_n), .HOST_CS(cs),
    .HOST_WE(we), .HOST_ADDR(addr), .HOST_WDATA(wdata), .HOST_RDATA(rdata),
    .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
    .BABBLE_EV(ev[0]), .MISSED_EV(ev[1]), .MEM_FAULT_EV(ev[2]), .RX_DONE_EV(ev[3]),
    .TX_DONE_EV(ev[4]), .FIFO_UNDERFLOW_EV(ev[5]), .BUFFER_ERROR_EV(ev[6]),
    .TX_POLL_TAKEN(taken), .TX_POLL_NOW(poll), .VME_IRQ(irq), .VME_IRQ_LEVEL(lvl),
    .HALTED(halted), .RX_ACTIVE(rxa), .TX_ACTIVE(txa), .NODE_ADDRESS(node),
    .MULTICAST_FILTER(filt), .RX_RING_BASE(rxb), .RX_RING_SIZE(rxs), .TX_RING_BASE(txb),
    .TX_RING_SIZE(txs), .ACCEPT_ALL(acc), .LOOPBACK(loop), .INTERNAL_ECHO(echo));
  lcsr_mem_model u_mem (.clk(clk), .reset_n(reset_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////
  // One host access; read data lands in v just after the taking edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    {cs, we, addr, wdata} <= {1'b1, w, a, d};
    @(posedge clk);
    cs <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic csr(input logic [1:0] s, input logic w, input logic [15:0] d);
    xfer(1'b1, lcsr_pkg::OFS_SELECT_PORT, {14'h0, s});
    xfer(w, lcsr_pkg::OFS_DATA_WINDOW, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 7'h00;
  endtask
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    csr(2'h0, 1'b0, 16'h0); chk("main", v, 16'h0004);
    csr(2'h1, 1'b1, 16'h1200);
    csr(2'h2, 1'b1, 16'h0056);
    csr(2'h3, 1'b1, 16'h0004);
    csr(2'h1, 1'b0, 16'h0); chk("ptr_low", v, 16'h1200);
    csr(2'h2, 1'b0, 16'h0); chk("ptr_high", v, 16'h0056);
    csr(2'h3, 1'b0, 16'h0); chk("bus_cfg", v, 16'h0004);
    $display("test pointers done");
    csr(2'h0, 1'b1, 16'h0003);
    repeat (200) if (rxa !== 1'b1) @(posedge clk);
    csr(2'h0, 1'b0, 16'h0); chk("main", v & 16'hfffe, 16'h01a2);
    chk("node", node, 48'ha003a002a001);
    chk("filter", filt, 64'ha007a006a005a004);
    chk("rx ring", {rxs, rxb}, {3'h5, 24'h09a008});
    chk("tx ring", {txs, txb}, {3'h5, 24'h0ba00a});
    chk("mode", {acc, loop, echo, txa}, 4'he);
    $display("test setup done");
    xfer(1'b1, lcsr_pkg::OFS_BOARD_CTRL, 16'h0003);
    cyc(3); chk("irq off", irq, 1'b0);
    csr(2'h0, 1'b1, 16'h0040);
    cyc(3); chk("irq on", irq, 1'b1);
    csr(2'h0, 1'b1, 16'h0140);
    cyc(3); chk("irq cleared", irq, 1'b0);
    pulse(7'h08);
    cyc(3); chk("irq gated", irq, 1'b0);
    xfer(1'b1, lcsr_pkg::OFS_BOARD_CTRL, 16'h0003);
    cyc(3); chk("irq reopened", irq, 1'b1);
    csr(2'h0, 1'b1, 16'h0048); chk("poll", poll, 1'b1);
    @(posedge clk);
    taken <= 1'b1;
    @(posedge clk);
    taken <= 1'b0;
    cyc(1); chk("poll used", poll, 1'b0);
    pulse(7'h77);
    cyc(2); chk("rx off", rxa, 1'b0);
    csr(2'h0, 1'b0, 16'h0); chk("main", v & 16'hfff0, 16'hdec0);
    csr(2'h1, 1'b0, 16'h0); chk("ptr running", v, 16'h0000);
    $display("test interrupt done");
    csr(2'h0, 1'b1, 16'h0007); chk("halt", {halted, mem_req}, 2'h2);
    csr(2'h0, 1'b0, 16'h0); chk("main", v, 16'h0004);
    csr(2'h1, 1'b0, 16'h0); chk("ptr lost", v, 16'h0000);
    csr(2'h1, 1'b1, 16'h1200);
    csr(2'h2, 1'b1, 16'h0056);
    csr(2'h3, 1'b1, 16'h0004);
    csr(2'h0, 1'b1, 16'h0002); chk("run", halted, 1'b0);
    chk("rx on", rxa, 1'b1);
    @(posedge clk);
    sysreset_n <= 1'b0;
    repeat (4) @(posedge clk);
    sysreset_n <= 1'b1;
    cyc(6); chk("sysreset", halted, 1'b1);
    $display("test halt done");
    summarize();
  end
endmodule // test_lan_csr_init_control
`default_nettype wire
